// *** logic/tcc_core.v ***
// tcc_core.v: completion, source clearing and interrupt forwarding of a transfer controller
// assumes the access engine is on the same clock and reports each finished transfer
// Notes on behaviour
// - raise cpu interrupt when count exhausted or interrupt select bit is one
// - forwarded interrupt is the same source that activated the transfer
// - forwarded requests still pass the interrupt controller mask and priority
// - operational after reset; module stop halts it and blocks enable register writes
// - module stop request is deferred while a transfer is active
// - dma channel enable bit just takes written data, not managed here
// - dma transfer-end activation flag is never auto-cleared
// - clearing happens only on the final transfer of a chain
// - peripheral sources clear only when the transfer touched their register
// - descriptor start address low two bits forced to zero
// - accesses split into several bus cycles by alignment and size
// - descriptor byte order on write and read must match
// - enable rewrite racing activation may double the interrupt
// - on completion clear source flag with no interrupt, or request interrupt and at count end clear enable bit
// - only chain member with chain enable zero clears and interrupts
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.vh"
module tcc_core #(
    parameter SRC_W = `TCC_SRC_W,
    parameter CNT_W = `TCC_CNT_W,
    parameter ADDR_W = `TCC_ADDR_W
) (
    input wire I_CLOCK,
    input wire I_RST_N,
    input wire I_STOP_REQ,
    input wire [SRC_W-1:0] I_SRC_ENABLE_SET,
    input wire [SRC_W-1:0] I_SRC_ENABLE_CLR,
    input wire [SRC_W-1:0] I_SRC_FLAG_CLR,
    input wire [SRC_W-1:0] I_SRC_FLAG_SET,
    input wire [SRC_W-1:0] I_SRC_DMAEND,
    input wire [SRC_W-1:0] I_SRC_PERIPH,
    input wire I_XFER_START,
    input wire I_XFER_DONE,
    input wire [SRC_W-1:0] I_XFER_SRC,
    input wire [CNT_W-1:0] I_XFER_COUNT,
    input wire I_XFER_INTERRUPT_SELECT_BIT,
    input wire I_XFER_CHAIN,
    input wire I_XFER_TOUCHED,
    input wire [ADDR_W-1:0] I_VECTOR_ADDR,
    output reg O_STOPPED,
    output reg O_BUSY,
    output reg [SRC_W-1:0] O_SRC_ENABLE,
    output reg [SRC_W-1:0] O_SRC_FLAG,
    output reg [SRC_W-1:0] O_CPU_IRQ,
    output reg [ADDR_W-1:0] O_DESC_ADDR
);
    reg busy_q;
    reg busy_d;
    reg stop_q;
    reg stop_d;
    reg [SRC_W-1:0] en_q;
    reg [SRC_W-1:0] en_d;
    reg [SRC_W-1:0] flag_q;
    reg [SRC_W-1:0] flag_d;
    reg [SRC_W-1:0] irq_q;
    reg [SRC_W-1:0] irq_d;
    reg [ADDR_W-1:0] desc_d;
    wire start_ok;
    wire stop_window;
    wire last_member;
    wire end_of_count;
    wire [SRC_W-1:0] en_clr_done;
    wire [SRC_W-1:0] flag_clr_done;
    wire [SRC_W-1:0] irq_set;
    genvar g;

    // a start is refused while stopped
    assign start_ok = I_XFER_START & ~stop_q;

    // stop only sampled when no transfer runs or is about to begin
    assign stop_window = ~busy_q & ~I_XFER_START;

    // completion decode, active only at the last member of a chain
    assign last_member = I_XFER_DONE & ~I_XFER_CHAIN & ~stop_q;

    assign end_of_count = (I_XFER_COUNT == `TCC_CNT_ZERO);

    generate
        for (g = 0; g < SRC_W; g = g + 1) begin : g_src
            wire hit;
            wire keep_periph;

            assign hit = last_member & I_XFER_SRC[g];

            // count exhausted or select bit set: raise the request
            assign irq_set[g] = hit & (end_of_count | I_XFER_INTERRUPT_SELECT_BIT);

            // dma end sources keep their enable; software owns that bit
            assign en_clr_done[g] = hit & end_of_count & ~I_SRC_DMAEND[g];

            // an untouched peripheral register leaves its source pending
            assign keep_periph = I_SRC_PERIPH[g] & ~I_XFER_TOUCHED;

            // dma end flags left alone; software must clear them
            assign flag_clr_done[g] = hit & ~end_of_count & ~I_XFER_INTERRUPT_SELECT_BIT
                & ~I_SRC_DMAEND[g] & ~keep_periph;
        end
    endgenerate

    // busy: set on an accepted start, cleared by the last chain member
    always @* begin
        busy_d = busy_q;
        if (start_ok) begin
            busy_d = 1'b1;
        end else if (I_XFER_DONE && !I_XFER_CHAIN) begin
            busy_d = 1'b0;
        end
    end

    // stop request held off while busy, so a transfer never freezes midway
    always @* begin
        stop_d = stop_q;
        if (stop_window) begin
            stop_d = I_STOP_REQ;
        end
    end

    // misaligned vectors are rounded down, never trapped
    always @* begin
        desc_d = O_DESC_ADDR;
        if (start_ok) begin
            desc_d = I_VECTOR_ADDR & `TCC_ALIGN_MASK;
        end
    end

    // enable writes blocked in stop; a racing set keeps both paths live
    always @* begin
        en_d = en_q;
        if (!stop_q) begin
            en_d = (en_q & ~I_SRC_ENABLE_CLR & ~en_clr_done) | I_SRC_ENABLE_SET;
        end
    end

    // hardware set wins over any clear in the same cycle
    always @* begin
        flag_d = (flag_q & ~I_SRC_FLAG_CLR & ~flag_clr_done) | I_SRC_FLAG_SET;
    end

    // request held until the cpu clears the flag; a new completion wins
    always @* begin
        irq_d = (irq_q & ~I_SRC_FLAG_CLR) | irq_set;
    end

    always @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            busy_q <= 1'b0;
            stop_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
            stop_q <= stop_d;
        end
    end

    always @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            en_q <= {SRC_W{1'b0}};
            flag_q <= {SRC_W{1'b0}};
            irq_q <= {SRC_W{1'b0}};
        end else begin
            en_q <= en_d;
            flag_q <= flag_d;
            irq_q <= irq_d;
        end
    end

    // word-aligned pointer only; bus splitting and byte order stay in the engine
    always @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_DESC_ADDR <= {ADDR_W{1'b0}};
        end else begin
            O_DESC_ADDR <= desc_d;
        end
    end

    // outputs registered; the interrupt controller applies mask and priority downstream
    always @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_STOPPED <= 1'b0;
            O_BUSY <= 1'b0;
            O_SRC_ENABLE <= {SRC_W{1'b0}};
            O_SRC_FLAG <= {SRC_W{1'b0}};
            O_CPU_IRQ <= {SRC_W{1'b0}};
        end else begin
            O_STOPPED <= stop_q;
            O_BUSY <= busy_q;
            O_SRC_ENABLE <= en_q;
            O_SRC_FLAG <= flag_q;
            O_CPU_IRQ <= irq_q & flag_q;
        end
    end
endmodule // tcc_core
`default_nettype wire

// *** inc/tcc_defs.vh ***
// tcc_defs.vh: constants for the transfer completion interrupt logic
// assumes inclusion by the single design file under logic/
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH
`define TCC_SRC_W 8
`define TCC_CNT_W 16
`define TCC_ADDR_W 32
`define TCC_CNT_ZERO 16'h0000
`define TCC_CNT_ONE 16'h0001
`define TCC_ALIGN_MASK 32'hfffffffc
`define TCC_KIND_PLAIN 2'h0
`define TCC_KIND_PERIPH 2'h1
`define TCC_KIND_DMAEND 2'h2
`endif

// *** testbench/tcc_core_properties.sv ***
// checker for tcc_core ports
// bound in from the bench, default widths
`timescale 1ns/1ps
`default_nettype none
module tcc_core_properties (input wire I_CLOCK, I_RST_N, I_STOP_REQ, I_XFER_START,
    input wire I_XFER_DONE, I_XFER_CHAIN, O_STOPPED, O_BUSY,
    input wire [7:0] I_SRC_FLAG_CLR, O_SRC_ENABLE, O_SRC_FLAG, O_CPU_IRQ,
    input wire [31:0] I_VECTOR_ADDR, O_DESC_ADDR);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);
    chk_addr_align: assert property (O_DESC_ADDR[1:0] == 2'h0) else $error("align");
    chk_addr_load: assert property (I_XFER_START && !O_STOPPED && !$past(I_STOP_REQ)
        |=> O_DESC_ADDR == {$past(I_VECTOR_ADDR[31:2]), 2'h0}) else $error("load");
    chk_irq_flag: assert property (!(O_CPU_IRQ & ~O_SRC_FLAG)) else $error("flag");
    chk_irq_hold: assert property (O_CPU_IRQ[0] && !I_SRC_FLAG_CLR[0]
        && !$past(I_SRC_FLAG_CLR[0]) |=> O_CPU_IRQ[0]) else $error("hold");
    chk_chain_quiet: assert property (I_XFER_DONE && I_XFER_CHAIN && !O_CPU_IRQ
        && !$past(I_XFER_DONE) |=> ##1 !O_CPU_IRQ) else $error("chain");
    chk_done_idle: assert property (I_XFER_DONE && !I_XFER_CHAIN && !I_XFER_START
        |=> ##1 !O_BUSY) else $error("idle");
    chk_stop_busy: assert property (O_BUSY |=> !$rose(O_STOPPED)) else $error("busy");
    chk_stop_freeze: assert property (O_STOPPED [*2] |-> $stable(O_SRC_ENABLE))
        else $error("freeze");
    cover property (O_CPU_IRQ[0]);
    cover property ($rose(O_STOPPED));
    cover property (I_XFER_DONE && I_XFER_CHAIN);
endmodule // tcc_core_properties
`default_nettype wire

// *** testbench/tcc_cpu_model.sv ***
// cpu side: acks a pending request some cycles later
// shares the bench clock
// software side keeps ram on, descriptors untouched, one byte order
`timescale 1ns/1ps
`default_nettype none
module tcc_cpu_model (input wire logic clk, input wire logic [7:0] irq, output logic [7:0] clr);
    logic [2:0] wait_q = 3'h0;
    always @(posedge clk) begin
        wait_q <= (|irq) ? wait_q + 3'h1 : 3'h0;
        clr <= (&wait_q) ? irq : 8'h00;
    end
endmodule // tcc_cpu_model
`default_nettype wire

// *** testbench/tcc_core_tb.sv ***
// bench for tcc_core
// needs the checker and cpu model
`timescale 1ns/1ps
`default_nettype none
module tcc_core_tb;
    logic I_CLOCK = 0, I_RST_N = 0, I_STOP_REQ = 0, I_XFER_START = 0, I_XFER_DONE = 0;
    logic I_XFER_CHAIN = 0, I_XFER_TOUCHED = 0, I_XFER_INTERRUPT_SELECT_BIT = 0, O_STOPPED, O_BUSY;
    logic [7:0] I_SRC_ENABLE_CLR = 0;
    logic [7:0] I_SRC_ENABLE_SET = 0, I_SRC_FLAG_SET = 0, I_XFER_SRC = 0, I_SRC_FLAG_CLR;
    logic [7:0] O_SRC_ENABLE, O_SRC_FLAG, O_CPU_IRQ;
    logic [15:0] I_XFER_COUNT = 0;
    logic [31:0] I_VECTOR_ADDR = 0, O_DESC_ADDR;
    int n_mismatch = 0, comparisons = 0, cycles = 0;
    tcc_core u_tcc_core (.I_SRC_DMAEND(8'h02), .I_SRC_PERIPH(8'h04), .*);
    tcc_cpu_model u_tcc_cpu_model (.clk(I_CLOCK), .irq(O_CPU_IRQ), .clr(I_SRC_FLAG_CLR));
    always #25 I_CLOCK = ~I_CLOCK;
    always @(posedge I_CLOCK) if (++cycles == 3000) begin n_mismatch++; end_of_test; end
    task automatic chk(string s, logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin n_mismatch++; $display("FAIL %s expected %h seen %h", s, e, g); end
    endtask
    task automatic ev(logic [7:0] b);
        @(posedge I_CLOCK) {I_SRC_FLAG_SET, I_SRC_ENABLE_SET} <= {b, b};
        @(posedge I_CLOCK) {I_SRC_FLAG_SET, I_SRC_ENABLE_SET} <= 16'h0000;
    endtask
    task automatic fin(logic [7:0] s, logic [15:0] c, logic ch, t, d = 0);
        @(posedge I_CLOCK) {I_XFER_DONE, I_XFER_SRC, I_XFER_COUNT} <= {1'h1, s, c};
        {I_XFER_CHAIN, I_XFER_TOUCHED, I_XFER_INTERRUPT_SELECT_BIT} <= {ch, t, d};
        @(posedge I_CLOCK) I_XFER_DONE <= 0;
        @(posedge I_CLOCK) #1;
    endtask
    task automatic t_chain; // chain on source 0, cpu acks late
        ev(8'h01);
        fin(8'h01, 0, 1, 0);
        chk("irq mid", 0, O_CPU_IRQ);
        fin(8'h01, 0, 0, 0);
        chk("irq end", 1, O_CPU_IRQ);
        chk("en end", 0, O_SRC_ENABLE);
        repeat (20) if (O_CPU_IRQ[0]) @(posedge I_CLOCK) #1;
        chk("irq ack", 0, O_CPU_IRQ);
    endtask
    task automatic t_keep; // dma end and untouched peripheral keep flags
        ev(8'h06);
        fin(8'h02, 5, 0, 0);
        fin(8'h04, 5, 0, 0);
        chk("flags kept", 8'h06, O_SRC_FLAG);
        fin(8'h04, 5, 0, 1);
        chk("periph clr", 8'h02, O_SRC_FLAG);
    endtask
    task automatic t_interrupt_select_bit; // select bit: irq after one transfer, flag and enable kept
        ev(8'h20);
        fin(8'h20, 5, 0, 0, 1);
        chk("interrupt_select_bit irq", 8'h20, O_CPU_IRQ);
        chk("interrupt_select_bit flag", 8'h22, O_SRC_FLAG);
        chk("interrupt_select_bit en", 8'h26, O_SRC_ENABLE);
        repeat (20) if (O_CPU_IRQ[5]) @(posedge I_CLOCK) #1;
        chk("interrupt_select_bit ack", 8'h02, O_SRC_FLAG);
        @(posedge I_CLOCK) I_SRC_ENABLE_CLR <= 8'h20;
        @(posedge I_CLOCK) I_SRC_ENABLE_CLR <= 8'h00;
        repeat (2) @(posedge I_CLOCK) #1;
        chk("en clr", 8'h06, O_SRC_ENABLE);
    endtask
    task automatic t_stop; // stop waits for idle, then enable edits are dropped
        @(posedge I_CLOCK) {I_XFER_START, I_VECTOR_ADDR} <= {1'h1, 32'h12345677};
        @(posedge I_CLOCK) {I_XFER_START, I_STOP_REQ} <= 2'h1;
        repeat (3) @(posedge I_CLOCK) #1;
        chk("desc", 32'h12345674, O_DESC_ADDR);
        chk("busy", 2'h2, {O_BUSY, O_STOPPED});
        fin(8'h10, 5, 0, 0);
        ev(8'h08);
        repeat (2) @(posedge I_CLOCK) #1;
        chk("stop", 2'h2, {O_STOPPED, O_SRC_ENABLE[3]});
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge I_CLOCK);
        I_RST_N <= 1;
        @(posedge I_CLOCK) #1;
        chk("reset", 0, {O_STOPPED, O_BUSY, O_SRC_ENABLE, O_CPU_IRQ});
        t_chain;
        t_keep;
        t_interrupt_select_bit;
        t_stop;
        end_of_test;
    end
endmodule // tcc_core_tb
bind tcc_core tcc_core_properties u_tcc_core_properties (.*);
`default_nettype wire
